// ==== tb_timer2_capture_reload_counter.sv ====
// Self-checking bench for the capture/reload timer
`timescale 1ns/10ps
`default_nettype none
module tb_timer2_capture_reload_counter;
    import tcr_pkg::*;
    logic clock = 1'h0;
    logic reset = 1'h1;
    logic ce = 1'h1;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    logic timer_irq_enable = 1'h0;
    logic other_timer_overflow = 1'h0;
    logic hready, hreadyout, hresp, count_pin, trigger_pin, timer_irq, rx_baud_tick, tx_baud_tick;
    logic [31:0] hrdata;
    int errors = 0;
    int samples_checked = 0;
    assign hready = hreadyout;
    always #50 clock = ~clock;
    tcr_top #(.PHASES(12)) i_dut (
        .clock(clock), .reset(reset), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .count_pin(count_pin),
        .trigger_pin(trigger_pin), .timer_irq_enable(timer_irq_enable), .timer_irq(timer_irq),
        .other_timer_overflow(other_timer_overflow), .rx_baud_tick(rx_baud_tick),
        .tx_baud_tick(tx_baud_tick)
    );
    tcr_pin_model i_pins (.clock(clock), .count_pin(count_pin), .trigger_pin(trigger_pin));
    // ==========================================================
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] v, output logic [31:0] d);
        @(posedge clock);
        hsel <= 1'h1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clock); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {24'h0, v};
        do @(posedge clock); while (hready !== 1'h1);
        d = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] d;
        bus(1'h1, idx, v, d);
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        bus(1'h0, idx, 8'h00, d);
        check($sformatf("register %h", idx), d, {24'h0, exp});
    endtask : rd
    task automatic set16(input logic [7:0] idx, input logic [15:0] v);
        wr(idx, v[7:0]);
        wr(idx + 8'h01, v[15:8]);
    endtask : set16
    // ==========================================================
    // Scenarios
    task automatic t_timer();
        set16(IDX_COUNT_LOW, 16'h0000);
        wr(IDX_CONTROL, 8'h05);
        // Run set for 150 clocks, 30 frozen by the clock enable: ten machine cycles
        repeat (57) @(posedge clock);
        ce <= 1'h0;
        repeat (30) @(posedge clock);
        ce <= 1'h1;
        repeat (60) @(posedge clock);
        wr(IDX_CONTROL, 8'h01);
        rd(IDX_COUNT_LOW, 8'h0A);
        repeat (40) @(posedge clock);
        rd(IDX_COUNT_LOW, 8'h0A);
        set16(IDX_COUNT_LOW, 16'hFFF8);
        wr(IDX_CONTROL, 8'h05);
        repeat (150) @(posedge clock);
        rd(IDX_CONTROL, 8'h85);
        rd(IDX_COUNT_HIGH, 8'h00);
        wr(IDX_CONTROL, 8'h01);
        rd(IDX_CONTROL, 8'h01);
    endtask : t_timer
    task automatic t_counter();
        set16(IDX_COUNT_LOW, 16'h0000);
        wr(IDX_CONTROL, 8'h07);
        repeat (3) i_pins.fall(1'h0);
        wr(IDX_CONTROL, 8'h03);
        rd(IDX_COUNT_LOW, 8'h03);
    endtask : t_counter
    task automatic t_capture();
        set16(IDX_COUNT_LOW, 16'h1234);
        set16(IDX_HOLD_LOW, 16'h0000);
        wr(IDX_CONTROL, 8'h01);
        i_pins.fall(1'h1);
        rd(IDX_HOLD_LOW, 8'h00);
        wr(IDX_CONTROL, 8'h09);
        i_pins.fall(1'h1);
        rd(IDX_HOLD_LOW, 8'h34);
        rd(IDX_HOLD_HIGH, 8'h12);
        rd(IDX_CONTROL, 8'h49);
        timer_irq_enable <= 1'h1;
        @(negedge clock);
        check("timer_irq", timer_irq, 1'h1);
        wr(IDX_MODE, 8'h01);
        @(negedge clock);
        check("timer_irq", timer_irq, 1'h0);
        wr(IDX_MODE, 8'h00);
        wr(IDX_CONTROL, 8'h09);
        rd(IDX_CONTROL, 8'h09);
    endtask : t_capture
    task automatic t_reload();
        set16(IDX_HOLD_LOW, 16'hABCD);
        set16(IDX_COUNT_LOW, 16'hFFFC);
        wr(IDX_CONTROL, 8'h04);
        repeat (100) @(posedge clock);
        rd(IDX_COUNT_HIGH, 8'hAB);
        rd(IDX_CONTROL, 8'h84);
        wr(IDX_CONTROL, 8'h08);
        set16(IDX_COUNT_LOW, 16'h0011);
        i_pins.fall(1'h1);
        rd(IDX_COUNT_LOW, 8'hCD);
        rd(IDX_CONTROL, 8'h48);
        wr(IDX_CONTROL, 8'h00);
    endtask : t_reload
    task automatic t_down();
        set16(IDX_HOLD_LOW, 16'h0005);
        set16(IDX_COUNT_LOW, 16'h0007);
        wr(IDX_MODE, 8'h01);
        i_pins.trigger_level(1'h0);
        wr(IDX_CONTROL, 8'h04);
        // Two steps down reach the hold value, the third underflows and loads all ones
        repeat (100) @(posedge clock);
        rd(IDX_COUNT_HIGH, 8'hFF);
        rd(IDX_CONTROL, 8'hC4);
        wr(IDX_CONTROL, 8'h00);
        wr(IDX_MODE, 8'h00);
        i_pins.trigger_level(1'h1);
    endtask : t_down
    task automatic t_baud();
        logic [7:0] ctl;
        int own;
        int oth;
        set16(IDX_HOLD_LOW, 16'hFFFE);
        set16(IDX_COUNT_LOW, 16'hFFFE);
        other_timer_overflow <= 1'h1;
        for (int i = 0; i < 2; i++) begin
            ctl = (i == 0) ? 8'h24 : 8'h14;
            wr(IDX_CONTROL, ctl);
            repeat (8) @(posedge clock);
            own = 0;
            oth = 0;
            // Wrap every two increments at one per two clocks gives a tick each four clocks
            repeat (40) begin
                @(negedge clock);
                own += ((i == 0 ? rx_baud_tick : tx_baud_tick) === 1'h1);
                oth += ((i == 0 ? tx_baud_tick : rx_baud_tick) === 1'h1);
            end
            check("own ticks", own, 32'h0000000A);
            check("other ticks", oth, 32'h00000028);
            wr(IDX_CONTROL, ctl & 8'hFB);
            repeat (20) @(posedge clock);
            rd(IDX_CONTROL, ctl & 8'hFB);
        end
        wr(IDX_CONTROL, 8'h00);
        other_timer_overflow <= 1'h0;
    endtask : t_baud
    // ==========================================================
    // Verdict
    task automatic results();
        $display("TB: %0d errors in %0d checks", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        $display("[FAIL] watchdog expected finish seen hang");
        results();
    end
    initial begin
        repeat (12) @(posedge clock);
        reset <= 1'h0;
        rd(IDX_CONTROL, CONTROL_RESET);
        rd(IDX_MODE, MODE_RESET);
        wr(8'hCE, 8'hFF);
        rd(8'hCE, 8'h00);
        t_timer();
        t_counter();
        t_capture();
        t_reload();
        t_down();
        t_baud();
        results();
    end
endmodule : tb_timer2_capture_reload_counter
`default_nettype wire

// ==== tcr_edge.sv ====
// Once-per-machine-cycle pin sampler with falling edge detection
`timescale 1ns/10ps
`default_nettype none
module tcr_edge (
    // Clocking
    input wire logic clock,
    input wire logic reset,
    input wire logic ce,
    // Sampled pin
    tcr_sample_if.sampler smp
);
    logic cur_ff, nxt_cur;
    logic prev_ff, nxt_prev;

    // ==========================================================
    // Sampling
    // A fall is high-then-low across two strobes; it stays visible for
    // the whole following machine cycle so the core can act once on it.
    always_comb begin
        nxt_cur = cur_ff;
        nxt_prev = prev_ff;
        if (smp.strobe) begin
            nxt_cur = smp.pin;
            nxt_prev = cur_ff;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cur_ff <= 1'b1;
            prev_ff <= 1'b1;
        end else if (ce) begin
            cur_ff <= nxt_cur;
            prev_ff <= nxt_prev;
        end
    end

    assign smp.level = cur_ff;
    assign smp.fall = prev_ff & ~cur_ff;
endmodule : tcr_edge
`default_nettype wire

// ==== tcr_pin_model.sv ====
// External source for the count and trigger pins
`timescale 1ns/10ps
`default_nettype none
module tcr_pin_model (
    // Clock
    input wire logic clock,
    // Pins
    output var logic count_pin,
    output var logic trigger_pin
);
    initial begin
        count_pin = 1'h1;
        trigger_pin = 1'h1;
    end
    // ==========================================================
    // One falling edge; each level stands two machine cycles so it is sampled
    task automatic fall(input logic trig);
        @(posedge clock);
        if (trig) trigger_pin <= 1'h0; else count_pin <= 1'h0;
        repeat (24) @(posedge clock);
        if (trig) trigger_pin <= 1'h1; else count_pin <= 1'h1;
        repeat (24) @(posedge clock);
    endtask : fall
    // Trigger held at a level, as a direction input for up/down counting
    task automatic trigger_level(input logic lvl);
        @(posedge clock);
        trigger_pin <= lvl;
    endtask : trigger_level
endmodule : tcr_pin_model
`default_nettype wire

// ==== tcr_pkg.sv ====
// Constants shared by the capture/reload timer, its port checks and its bench
package tcr_pkg;
    // ==========================================================
    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_CONTROL = 8'hC8;
    localparam logic [7:0] IDX_MODE = 8'hC9;
    localparam logic [7:0] IDX_HOLD_LOW = 8'hCA;
    localparam logic [7:0] IDX_HOLD_HIGH = 8'hCB;
    localparam logic [7:0] IDX_COUNT_LOW = 8'hCC;
    localparam logic [7:0] IDX_COUNT_HIGH = 8'hCD;
    localparam int ADDR_BITS = 10;

    // ==========================================================
    // Control and mode register fields
    localparam int B_OVERFLOW = 7;
    localparam int B_EXT_EDGE = 6;
    localparam int B_RX_BAUD = 5;
    localparam int B_TX_BAUD = 4;
    localparam int B_EXT_EN = 3;
    localparam int B_RUN = 2;
    localparam int B_SOURCE = 1;
    localparam int B_CAPTURE = 0;
    localparam int B_DOWN_EN = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;

    // ==========================================================
    // Machine cycle timing: six states of two phases each
    localparam int PHASES_PER_CYCLE = 12;
    localparam logic [3:0] PHASE_LAST = 4'hB;
    localparam logic [3:0] PHASE_S3P1 = 4'h4;
    localparam logic [3:0] PHASE_S5P2 = 4'h9;
endpackage : tcr_pkg

// ==== tcr_sample_if.sv ====
// Link between the timer core and one pin sampler
`timescale 1ns/10ps
`default_nettype none
interface tcr_sample_if;
    logic strobe;
    logic pin;
    logic level;
    logic fall;
    modport sampler (input strobe, input pin, output level, output fall);
    modport core (output strobe, output pin, input level, input fall);
endinterface : tcr_sample_if
`default_nettype wire

// ==== tcr_top.sv ====
// Capture/reload/baud timer with an AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Overflow flag set by count overflow; cleared only by software write.
// - Overflow flag never set while either baud select bit is one.
// - External edge flag set when a trigger fall causes capture or reload.
// - Interrupt request raised while enabled and external edge flag is one.
// - External edge flag raises no interrupt while down count enable is set.
// - Receive baud select picks this timer's overflows, else the other timer's.
// - Transmit baud select picks this timer's overflows, else the other timer's.
// - Trigger pin ignored unless trigger enable, except as up/down direction; no reload in baud mode.
// - Counting only while run control is one.
// - Source select zero counts machine cycles; one counts count pin falls.
// - Capture select: falls capture; else reloads; baud forces reload.
// - Mode decode: baud, 16-bit auto-reload, or 16-bit capture.
// - Timer function increments once per twelve-period machine cycle.
// - Count pin sampled at S5P2; high then low increments.
// - Incremented count appears at S3P1 of the following machine cycle.
// - Capture mode without trigger is a plain timer flagging each overflow.
// - Capture mode trigger fall copies count into hold, sets edge flag.
// - Up auto-reload overflow past all ones loads the hold pair.
// - Down count underflows at hold value, flags overflow, loads all ones.
// - Baud mode timer increments every state time.
// - Down count enable resets to zero.
module tcr_top
    import tcr_pkg::*;
#(
    parameter int PHASES = tcr_pkg::PHASES_PER_CYCLE
) (
    // Clocking
    input wire logic clock,
    input wire logic reset,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Pins
    input wire logic count_pin,
    input wire logic trigger_pin,
    // Interrupt and serial port
    input wire logic timer_irq_enable,
    output logic timer_irq,
    input wire logic other_timer_overflow,
    output logic rx_baud_tick,
    output logic tx_baud_tick
);
    import tcr_pkg::*;

    // ==========================================================
    // Elaboration check
    if (PHASES != PHASES_PER_CYCLE) begin : g_bad_phases
        $error("tcr_top: machine cycle must be twelve phases");
    end

    // ==========================================================
    // State
    logic [7:0] control_ff, nxt_control;
    logic [7:0] mode_ff, nxt_mode;
    logic [15:0] count_ff, nxt_count;
    logic [15:0] hold_ff, nxt_hold;
    logic [3:0] phase_ff, nxt_phase;
    logic own_ovf_ff, nxt_own_ovf;
    logic wr_pend_ff, nxt_wr_pend;
    logic [7:0] wr_idx_ff, nxt_wr_idx;
    logic [31:0] hrdata_ff, nxt_hrdata;

    tcr_sample_if cnt_smp ();
    tcr_sample_if trg_smp ();

    tcr_edge u_count_edge (
        .clock(clock),
        .reset(reset),
        .ce(ce),
        .smp(cnt_smp.sampler)
    );

    tcr_edge u_trigger_edge (
        .clock(clock),
        .reset(reset),
        .ce(ce),
        .smp(trg_smp.sampler)
    );

    // ==========================================================
    // Machine cycle sequencing
    logic at_s3p1;
    logic at_s5p2;
    logic state_tick;

    always_comb begin
        nxt_phase = (phase_ff == PHASE_LAST) ? 4'h0 : phase_ff + 4'h1;
    end

    assign at_s3p1 = (phase_ff == PHASE_S3P1);
    assign at_s5p2 = (phase_ff == PHASE_S5P2);
    assign state_tick = ~phase_ff[0];

    // Both pins share one sampling point per machine cycle
    assign cnt_smp.strobe = at_s5p2;
    assign cnt_smp.pin = count_pin;
    assign trg_smp.strobe = at_s5p2;
    assign trg_smp.pin = trigger_pin;

    // ==========================================================
    // Mode decode
    logic run;
    logic baud_mode;
    logic capture_mode;
    logic reload_mode;
    logic down_en;
    logic count_down;
    logic inc_event;
    logic trig_event;
    logic wrap;

    assign run = control_ff[B_RUN];
    assign baud_mode = control_ff[B_RX_BAUD] | control_ff[B_TX_BAUD];
    assign capture_mode = ~baud_mode & control_ff[B_CAPTURE];
    assign reload_mode = ~baud_mode & ~control_ff[B_CAPTURE];
    assign down_en = mode_ff[B_DOWN_EN];
    // In up/down mode the trigger pin is the direction, not a trigger
    assign count_down = reload_mode & down_en & ~trg_smp.level;

    always_comb begin
        inc_event = 1'b0;
        if (run) begin
            if (control_ff[B_SOURCE]) begin
                inc_event = cnt_smp.fall & at_s3p1;
            end else if (baud_mode) begin
                inc_event = state_tick;
            end else begin
                inc_event = at_s3p1;
            end
        end
    end

    // Trigger falls act at S3P1 like count pin falls
    assign trig_event = control_ff[B_EXT_EN] & trg_smp.fall & at_s3p1
        & ~(reload_mode & down_en);

    // Up wraps past all ones; down ends when the count meets the hold pair
    assign wrap = inc_event & (count_down ? (count_ff == hold_ff) : (count_ff == COUNT_ALL_ONES));

    // ==========================================================
    // Bus access decode
    logic addr_phase;
    logic [7:0] rd_idx;
    logic wr_control, wr_mode, wr_hold_l, wr_hold_h, wr_count_l, wr_count_h;

    assign addr_phase = ce & hsel & hready & htrans[1];
    assign rd_idx = haddr[ADDR_BITS-1:2];
    assign wr_control = wr_pend_ff & (wr_idx_ff == IDX_CONTROL);
    assign wr_mode = wr_pend_ff & (wr_idx_ff == IDX_MODE);
    assign wr_hold_l = wr_pend_ff & (wr_idx_ff == IDX_HOLD_LOW);
    assign wr_hold_h = wr_pend_ff & (wr_idx_ff == IDX_HOLD_HIGH);
    assign wr_count_l = wr_pend_ff & (wr_idx_ff == IDX_COUNT_LOW);
    assign wr_count_h = wr_pend_ff & (wr_idx_ff == IDX_COUNT_HIGH);

    always_comb begin
        nxt_wr_pend = addr_phase & hwrite;
        nxt_wr_idx = addr_phase ? rd_idx : wr_idx_ff;
        nxt_hrdata = hrdata_ff;
        if (addr_phase & ~hwrite) begin
            if (rd_idx == IDX_CONTROL) begin
                nxt_hrdata = {24'h000000, control_ff};
            end else if (rd_idx == IDX_MODE) begin
                nxt_hrdata = {24'h000000, mode_ff};
            end else if (rd_idx == IDX_HOLD_LOW) begin
                nxt_hrdata = {24'h000000, hold_ff[7:0]};
            end else if (rd_idx == IDX_HOLD_HIGH) begin
                nxt_hrdata = {24'h000000, hold_ff[15:8]};
            end else if (rd_idx == IDX_COUNT_LOW) begin
                nxt_hrdata = {24'h000000, count_ff[7:0]};
            end else if (rd_idx == IDX_COUNT_HIGH) begin
                nxt_hrdata = {24'h000000, count_ff[15:8]};
            end else begin
                nxt_hrdata = 32'h00000000;
            end
        end
    end

    // ==========================================================
    // Counter, hold pair and flags
    logic set_ovf;
    logic set_ext;
    logic toggle_ext;

    // Baud mode never raises the overflow flag
    assign set_ovf = wrap & ~baud_mode;
    // Every trigger event that reaches here is a capture, a reload or a bare flag
    assign set_ext = trig_event;
    // In up/down mode the edge flag acts as a seventeenth count bit
    assign toggle_ext = wrap & reload_mode & down_en;

    always_comb begin
        nxt_count = count_ff;
        nxt_hold = hold_ff;
        nxt_control = control_ff;
        nxt_mode = mode_ff;
        nxt_own_ovf = wrap & baud_mode;

        // Software writes first, hardware events override them below
        if (wr_control) begin
            nxt_control = hwdata[7:0];
        end
        if (wr_mode) begin
            nxt_mode = {7'h00, hwdata[B_DOWN_EN]};
        end
        if (wr_hold_l) begin
            nxt_hold[7:0] = hwdata[7:0];
        end
        if (wr_hold_h) begin
            nxt_hold[15:8] = hwdata[7:0];
        end
        if (wr_count_l) begin
            nxt_count[7:0] = hwdata[7:0];
        end
        if (wr_count_h) begin
            nxt_count[15:8] = hwdata[7:0];
        end

        if (wrap) begin
            if (count_down) begin
                nxt_count = COUNT_ALL_ONES;
            end else if (capture_mode) begin
                nxt_count = COUNT_RESET;
            end else begin
                nxt_count = hold_ff;
            end
        end else if (inc_event) begin
            nxt_count = count_down ? count_ff - 16'h0001 : count_ff + 16'h0001;
        end

        if (trig_event & capture_mode) begin
            nxt_hold = count_ff;
        end else if (trig_event & reload_mode & ~wrap) begin
            nxt_count = hold_ff;
        end

        // A hardware set wins over a same-cycle software clear
        if (set_ovf) begin
            nxt_control[B_OVERFLOW] = 1'b1;
        end
        if (set_ext) begin
            nxt_control[B_EXT_EDGE] = 1'b1;
        end else if (toggle_ext) begin
            nxt_control[B_EXT_EDGE] = ~control_ff[B_EXT_EDGE];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            control_ff <= CONTROL_RESET;
            mode_ff <= MODE_RESET;
            count_ff <= COUNT_RESET;
            hold_ff <= COUNT_RESET;
            phase_ff <= 4'h0;
            own_ovf_ff <= 1'b0;
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 8'h00;
            hrdata_ff <= 32'h00000000;
        end else if (ce) begin
            control_ff <= nxt_control;
            mode_ff <= nxt_mode;
            count_ff <= nxt_count;
            hold_ff <= nxt_hold;
            phase_ff <= nxt_phase;
            own_ovf_ff <= nxt_own_ovf;
            wr_pend_ff <= nxt_wr_pend;
            wr_idx_ff <= nxt_wr_idx;
            hrdata_ff <= nxt_hrdata;
        end
    end

    // ==========================================================
    // Outputs
    // Stalling the bus while frozen keeps writes from being lost
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;

    // The edge flag is masked in up/down mode, where it only toggles
    assign timer_irq = timer_irq_enable & (control_ff[B_OVERFLOW]
        | (control_ff[B_EXT_EDGE] & ~down_en));

    // The serial port uses these ticks in its modes 1 and 3
    assign rx_baud_tick = control_ff[B_RX_BAUD] ? own_ovf_ff : other_timer_overflow;
    assign tx_baud_tick = control_ff[B_TX_BAUD] ? own_ovf_ff : other_timer_overflow;

endmodule : tcr_top
`default_nettype wire

// ==== tcr_top_properties.sv ====
// Port-level checks on the capture/reload timer
`timescale 1ns/10ps
`default_nettype none
module tcr_top_properties
    import tcr_pkg::*;
#(
    parameter int PHASES = 12
) (
    // Clocking
    input wire logic clock,
    input wire logic reset,
    input wire logic ce,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Interrupt and serial port
    input wire logic timer_irq_enable,
    input wire logic timer_irq,
    input wire logic other_timer_overflow,
    input wire logic rx_baud_tick
);
    logic taken;
    logic rd_hole;
    logic wr_ctl_ff;
    logic nxt_wr_ctl;
    logic [5:0] cfg_ff;
    logic [5:0] nxt_cfg;
    // ==========================================================
    // Shadow of software-owned control bits; flags skipped as hardware moves them
    always_comb begin
        taken = hsel && hready && htrans[1] && ce;
        rd_hole = taken && !hwrite && (haddr[ADDR_BITS-1:2] < IDX_CONTROL
            || haddr[ADDR_BITS-1:2] > IDX_COUNT_HIGH);
        nxt_wr_ctl = (wr_ctl_ff && !hready)
            || (taken && hwrite && haddr[ADDR_BITS-1:2] == IDX_CONTROL);
        nxt_cfg = (wr_ctl_ff && hready) ? hwdata[5:0] : cfg_ff;
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wr_ctl_ff <= 1'h0;
            cfg_ff <= 6'h00;
        end else begin
            wr_ctl_ff <= nxt_wr_ctl;
            cfg_ff <= nxt_cfg;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    AST_IRQ_ENABLE: assert property (!timer_irq_enable |-> !timer_irq)
        else $error("interrupt raised while disabled");
    AST_RX_OTHER: assert property (!cfg_ff[5] |-> rx_baud_tick == other_timer_overflow)
        else $error("receive tick not from other timer");
    AST_RX_PULSE: assert property (cfg_ff[5] && rx_baud_tick |=> !rx_baud_tick || !cfg_ff[5])
        else $error("own receive tick longer than one clock");
    // Depth two covers the tick that is registered one clock after the last wrap
    AST_RX_STOPPED: assert property (cfg_ff[5] && !cfg_ff[2] && !$past(cfg_ff[2])
        && !$past(cfg_ff[2], 2) |-> !rx_baud_tick) else $error("tick while stopped");
    AST_HREADY_CE: assert property (hreadyout == ce)
        else $error("ready does not follow clock enable");
    AST_HRESP_OKAY: assert property (!hresp)
        else $error("error response");
    AST_HRDATA_BYTE: assert property ($stable(hrdata[31:8]) && hrdata[31:8] == 24'h0)
        else $error("read data above byte not zero");
    AST_UNMAPPED_ZERO: assert property (rd_hole |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    COV_OWN_TICK: cover property (cfg_ff[5] && rx_baud_tick);
    COV_IRQ: cover property (timer_irq);
    COV_HOLE: cover property (rd_hole);
endmodule : tcr_top_properties
bind tcr_top tcr_top_properties #(.PHASES(PHASES)) i_props (
    .clock(clock), .reset(reset), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .timer_irq_enable(timer_irq_enable),
    .timer_irq(timer_irq), .other_timer_overflow(other_timer_overflow),
    .rx_baud_tick(rx_baud_tick)
);
`default_nettype wire
